// ---- hdl/fspg_guard.sv ----
// Flash self-program guard: protection fields, address split, AHB-Lite registers.
`default_nettype none

module fspg_guard #(
   parameter int ADDR_BITS = 16
) (
   input  wire logic        sys_clk,
   input  wire logic        arst_n,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   input  wire logic        ivec_in_boot,
   output logic             irq_mask,
   output logic             flash_store_en,
   output logic             flash_load_en,
   output logic [15:0]      flash_addr,
   output logic             flash_byte_hi
);
   // ----------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------
   // The pointer is a plain software register; operations never read it
   // directly, they carry their own pointer in the command word so that
   // a later pointer write cannot disturb an operation already issued.
   // The two protection fields hold 1 for unprogrammed, 0 for programmed.
   logic [15:0] pointer_r;
   logic [1:0]  app_protect_field_r;
   logic [1:0]  boot_protect_field_r;
   logic [1:0]  boot_size_fuses_r;
   logic        exec_in_boot_r;
   logic        ap_valid_r;
   logic [7:0]  ap_addr_r;
   logic        ap_write_r;
   logic        store_seen_r;
   logic        load_seen_r;
   logic        blocked_r;
   fspg_pkg::fspg_op_t op_r;

   // ----------------------------------------------------------------------
   // Address decode and protection logic
   // ----------------------------------------------------------------------
   logic [15:0] boundary;
   logic        tgt_boot;
   logic        store_ok;
   logic        load_ok;
   logic        wr_cmd;
   logic [31:0] wd;

   assign wd = hwdata;
   assign wr_cmd = ap_valid_r & ap_write_r & (ap_addr_r == fspg_pkg::OFF_CMD);

   // Boot section sits at the top; size fuses pick 512..4096 bytes
   always_comb begin
      case (boot_size_fuses_r)
         2'h0:    boundary = 16'hf000;
         2'h1:    boundary = 16'hf800;
         2'h2:    boundary = 16'hfc00;
         default: boundary = 16'hfe00;
      endcase
   end

   // Target section from pointer in the command word
   // Only meaningful while wr_cmd is high; at other times hwdata may hold
   // anything, so every consumer qualifies its use with wr_cmd.
   assign tgt_boot = (wd[31:16] >= boundary);

   // Protection table; lock-mode bits of other units are not consulted
   // Store needs boot-issued code and an open low bit of the target field;
   // load is only refused when the high bit is programmed and the code
   // runs from the other section. Kept combinational so a field change
   // acts on the very next command with no stale decode in between.
   always_comb begin
      store_ok = wd[fspg_pkg::CMD_FROM_BOOT];
      load_ok  = 1'b1;
      if (tgt_boot) begin
         if (!boot_protect_field_r[0]) store_ok = 1'b0;
         if (!boot_protect_field_r[1] && !wd[fspg_pkg::CMD_FROM_BOOT])
            load_ok = 1'b0;
      end else begin
         if (!app_protect_field_r[0]) store_ok = 1'b0;
         if (!app_protect_field_r[1] && wd[fspg_pkg::CMD_FROM_BOOT])
            load_ok = 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // AHB-Lite slave: zero wait, OKAY always
   // ----------------------------------------------------------------------
   // Address phase is held for one cycle so writes act in the data phase,
   // when hwdata is valid. Only whole-word writes are taken; narrower
   // ones are dropped rather than merged, which keeps the decode small.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         ap_valid_r <= 1'b0;
         ap_addr_r  <= 8'h00;
         ap_write_r <= 1'b0;
      end else if (hready) begin
         ap_valid_r <= hsel & htrans[1] & (hsize == fspg_pkg::HSIZE_WORD);
         ap_addr_r  <= haddr[7:0];
         ap_write_r <= hwrite;
      end
   end

   // Pointer and fuse writes
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         pointer_r         <= fspg_pkg::PTR_RESET;
         boot_size_fuses_r <= fspg_pkg::BOOT_SIZE_RST;
         exec_in_boot_r    <= 1'b0;
      end else if (ap_valid_r && ap_write_r) begin
         if (ap_addr_r == fspg_pkg::OFF_POINTER)
            pointer_r <= wd[15:0];
         if (ap_addr_r == fspg_pkg::OFF_CONFIG) begin
            boot_size_fuses_r <= wd[1:0];
            exec_in_boot_r    <= wd[2];
         end
      end
   end

   // Protection fields: AND only tightens; erase key restores
   // The erase key stands in for a full chip erase, the only way back to
   // the unprogrammed state. Lock setting from app code is ignored.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         app_protect_field_r  <= fspg_pkg::PROT_UNPROG;
         boot_protect_field_r <= fspg_pkg::PROT_UNPROG;
      end else if (ap_valid_r && ap_write_r) begin
         if (ap_addr_r == fspg_pkg::OFF_ERASE_KEY && wd == fspg_pkg::ERASE_KEY) begin
            app_protect_field_r  <= fspg_pkg::PROT_UNPROG;
            boot_protect_field_r <= fspg_pkg::PROT_UNPROG;
         end else if ((ap_addr_r == fspg_pkg::OFF_PROTECT) ||
                      (wr_cmd && wd[fspg_pkg::CMD_SETLOCK] && wd[fspg_pkg::CMD_FROM_BOOT])) begin
            // Pointer is not consulted for lock setting
            app_protect_field_r  <= app_protect_field_r & wd[9:8];
            boot_protect_field_r <= boot_protect_field_r & wd[11:10];
         end
      end
   end

   // Operation capture: address latched so pointer may change after
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         op_r <= '0;
      end else if (wr_cmd && !wd[fspg_pkg::CMD_SETLOCK]) begin
         op_r.ptr     <= wd[31:16];
         op_r.store   <= wd[fspg_pkg::CMD_STORE];
         op_r.load    <= wd[fspg_pkg::CMD_LOAD];
         op_r.allowed <= wd[fspg_pkg::CMD_STORE] ? store_ok : load_ok;
      end
   end

   // Observational flags; blocked accesses raise no error
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         store_seen_r <= 1'b0;
         load_seen_r  <= 1'b0;
         blocked_r    <= 1'b0;
      end else if (wr_cmd && !wd[fspg_pkg::CMD_SETLOCK]) begin
         store_seen_r <= wd[fspg_pkg::CMD_STORE] & store_ok;
         load_seen_r  <= wd[fspg_pkg::CMD_LOAD] & load_ok;
         blocked_r    <= wd[fspg_pkg::CMD_STORE] ? !store_ok : !load_ok;
      end
   end

   // ----------------------------------------------------------------------
   // Flash-side outputs, all registered
   // ----------------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         flash_store_en <= 1'b0;
         flash_load_en  <= 1'b0;
         flash_addr     <= 16'h0000;
         flash_byte_hi  <= 1'b0;
      end else begin
         flash_store_en <= wr_cmd & !wd[fspg_pkg::CMD_SETLOCK] & wd[fspg_pkg::CMD_STORE] & store_ok;
         flash_load_en  <= wr_cmd & !wd[fspg_pkg::CMD_SETLOCK] & wd[fspg_pkg::CMD_LOAD] & load_ok;
         if (wr_cmd && !wd[fspg_pkg::CMD_SETLOCK]) begin
            // Word address: drop byte bit; page in upper, word in lower bits
            flash_addr    <= {1'b0, wd[31:17]};
            flash_byte_hi <= wd[16];
         end
      end
   end

   // Interrupt mask while running from the unprotected-vector side
   // Modes 3 and 4 share a programmed high bit, so that bit alone decides.
   // The mask is one cycle behind its inputs since it comes from a flop.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         irq_mask <= 1'b0;
      end else begin
         irq_mask <= (ivec_in_boot && !exec_in_boot_r && !app_protect_field_r[1]) ||
                     (!ivec_in_boot && exec_in_boot_r && !boot_protect_field_r[1]);
      end
   end

   // Read data registered for the data phase
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         hrdata    <= 32'h0000_0000;
         if (hready && hsel && htrans[1] && !hwrite) begin
            case (haddr[7:0])
               fspg_pkg::OFF_POINTER: hrdata <= {16'h0000, pointer_r};
               fspg_pkg::OFF_PROTECT: hrdata <= {20'h00000, boot_protect_field_r,
                                                 app_protect_field_r, 8'h00};
               fspg_pkg::OFF_CONFIG:  hrdata <= {29'h0, exec_in_boot_r, boot_size_fuses_r};
               fspg_pkg::OFF_ADDR:    hrdata <= {op_r.ptr, 13'h0, op_r.store, op_r.load,
                                                 op_r.allowed};
               fspg_pkg::OFF_STATUS:  hrdata <= {29'h0, blocked_r, load_seen_r, store_seen_r};
               default:               hrdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   chk_prot_no_loosen: assert property (@(posedge sys_clk) disable iff (!arst_n)
      !(ap_valid_r && ap_write_r && ap_addr_r == fspg_pkg::OFF_ERASE_KEY && wd == fspg_pkg::ERASE_KEY)
      |=> (app_protect_field_r & ~$past(app_protect_field_r)) == 2'h0)
      else $error("app protection loosened without erase");
   chk_app_store_block: assert property (@(posedge sys_clk) disable iff (!arst_n)
      wr_cmd && wd[fspg_pkg::CMD_STORE] && !tgt_boot && !app_protect_field_r[0]
      |=> !flash_store_en)
      else $error("store to protected app passed");
   chk_boot_store_block: assert property (@(posedge sys_clk) disable iff (!arst_n)
      wr_cmd && wd[fspg_pkg::CMD_STORE] && tgt_boot && !boot_protect_field_r[0]
      |=> !flash_store_en)
      else $error("store to protected boot passed");
   chk_app_load_block: assert property (@(posedge sys_clk) disable iff (!arst_n)
      wr_cmd && wd[fspg_pkg::CMD_LOAD] && !tgt_boot && !app_protect_field_r[1]
      && wd[fspg_pkg::CMD_FROM_BOOT] && !wd[fspg_pkg::CMD_SETLOCK] |=> !flash_load_en)
      else $error("boot read of app passed");
   chk_boot_load_block: assert property (@(posedge sys_clk) disable iff (!arst_n)
      wr_cmd && wd[fspg_pkg::CMD_LOAD] && tgt_boot && !boot_protect_field_r[1]
      && !wd[fspg_pkg::CMD_FROM_BOOT] && !wd[fspg_pkg::CMD_SETLOCK] |=> !flash_load_en)
      else $error("app read of boot passed");
   chk_store_from_app: assert property (@(posedge sys_clk) disable iff (!arst_n)
      wr_cmd && !wd[fspg_pkg::CMD_FROM_BOOT] |=> !flash_store_en)
      else $error("store from app code passed");
   chk_addr_latched: assert property (@(posedge sys_clk) disable iff (!arst_n)
      wr_cmd && !wd[fspg_pkg::CMD_SETLOCK] |=> flash_addr == {1'b0, $past(wd[31:17])}
      && flash_byte_hi == $past(wd[16]))
      else $error("target address not captured");
   chk_irq_mask_app: assert property (@(posedge sys_clk) disable iff (!arst_n)
      ivec_in_boot && !exec_in_boot_r && !app_protect_field_r[1] |=> irq_mask)
      else $error("interrupt not masked");
   chk_irq_mask_boot: assert property (@(posedge sys_clk) disable iff (!arst_n)
      !ivec_in_boot && exec_in_boot_r && !boot_protect_field_r[1] |=> irq_mask)
      else $error("interrupt not masked in boot");

   // ----------------------------------------------------------------------
   // Checks on the open modes, mode 4 and lock setting
   // ----------------------------------------------------------------------
   // Unprogrammed app field lets a boot-issued store through
   chk_app_open_store: assert property (@(posedge sys_clk) disable iff (!arst_n)
      wr_cmd && !wd[fspg_pkg::CMD_SETLOCK] && wd[fspg_pkg::CMD_STORE] && wd[fspg_pkg::CMD_FROM_BOOT]
      && !tgt_boot && app_protect_field_r == 2'h3 |=> flash_store_en)
      else $error("store to open app refused");

   // Unprogrammed boot field lets a boot-issued store through
   chk_boot_open_store: assert property (@(posedge sys_clk) disable iff (!arst_n)
      wr_cmd && !wd[fspg_pkg::CMD_SETLOCK] && wd[fspg_pkg::CMD_STORE] && wd[fspg_pkg::CMD_FROM_BOOT]
      && tgt_boot && boot_protect_field_r == 2'h3 |=> flash_store_en)
      else $error("store to open boot refused");

   // App mode 2 still allows loads
   chk_app_mode2_load: assert property (@(posedge sys_clk) disable iff (!arst_n)
      wr_cmd && !wd[fspg_pkg::CMD_SETLOCK] && wd[fspg_pkg::CMD_LOAD] && !tgt_boot
      && app_protect_field_r == 2'h2 |=> flash_load_en)
      else $error("load in app mode 2 refused");

   // App mode 4 allows stores
   chk_app_mode4_store: assert property (@(posedge sys_clk) disable iff (!arst_n)
      wr_cmd && !wd[fspg_pkg::CMD_SETLOCK] && wd[fspg_pkg::CMD_STORE] && wd[fspg_pkg::CMD_FROM_BOOT]
      && !tgt_boot && app_protect_field_r == 2'h1 |=> flash_store_en)
      else $error("store in app mode 4 refused");

   // App mode 4 refuses boot-issued loads of the app section
   chk_app_mode4_load: assert property (@(posedge sys_clk) disable iff (!arst_n)
      wr_cmd && !wd[fspg_pkg::CMD_SETLOCK] && wd[fspg_pkg::CMD_LOAD] && wd[fspg_pkg::CMD_FROM_BOOT]
      && !tgt_boot && app_protect_field_r == 2'h1 |=> !flash_load_en)
      else $error("boot read of app in mode 4 passed");

   // Boot mode 4 allows stores
   chk_boot_mode4_store: assert property (@(posedge sys_clk) disable iff (!arst_n)
      wr_cmd && !wd[fspg_pkg::CMD_SETLOCK] && wd[fspg_pkg::CMD_STORE] && wd[fspg_pkg::CMD_FROM_BOOT]
      && tgt_boot && boot_protect_field_r == 2'h1 |=> flash_store_en)
      else $error("store in boot mode 4 refused");

   // Boot mode 4 refuses app-issued loads of the boot section
   chk_boot_mode4_load: assert property (@(posedge sys_clk) disable iff (!arst_n)
      wr_cmd && !wd[fspg_pkg::CMD_SETLOCK] && wd[fspg_pkg::CMD_LOAD] && !wd[fspg_pkg::CMD_FROM_BOOT]
      && tgt_boot && boot_protect_field_r == 2'h1 |=> !flash_load_en)
      else $error("app read of boot in mode 4 passed");

   // Loads into an app field with open high bit always pass
   chk_load_open_app: assert property (@(posedge sys_clk) disable iff (!arst_n)
      wr_cmd && !wd[fspg_pkg::CMD_SETLOCK] && wd[fspg_pkg::CMD_LOAD] && !tgt_boot
      && app_protect_field_r[1] |=> flash_load_en)
      else $error("load of open app refused");

   // A refused store raises the blocked flag and gives no store pulse
   chk_blocked_flag: assert property (@(posedge sys_clk) disable iff (!arst_n)
      wr_cmd && !wd[fspg_pkg::CMD_SETLOCK] && wd[fspg_pkg::CMD_STORE] && !store_ok
      |=> blocked_r && !flash_store_en)
      else $error("refused store not dropped");

   // Lock setting uses the data word only, never the pointer
   chk_lock_no_ptr: assert property (@(posedge sys_clk) disable iff (!arst_n)
      wr_cmd && wd[fspg_pkg::CMD_SETLOCK] && wd[fspg_pkg::CMD_FROM_BOOT]
      |=> app_protect_field_r == ($past(app_protect_field_r) & $past(wd[9:8])))
      else $error("lock setting not taken from data");

   // The slave never signals an error
   chk_bus_okay: assert property (@(posedge sys_clk) disable iff (!arst_n)
      !hresp && hreadyout)
      else $error("bus response not okay");

   cov_store_ok:   cover property (@(posedge sys_clk) flash_store_en);
   cov_load_ok:    cover property (@(posedge sys_clk) flash_load_en);
   cov_blocked:    cover property (@(posedge sys_clk) blocked_r);
   cov_irq_masked: cover property (@(posedge sys_clk) irq_mask);
endmodule : fspg_guard
`default_nettype wire

// ---- pkg/fspg_pkg.sv ----
// Package for the flash self-program guard: register map, field layout, bus codes.
`default_nettype none
package fspg_pkg;
   // ----------------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------------
   localparam logic [7:0] OFF_POINTER   = 8'h00;
   localparam logic [7:0] OFF_PROTECT   = 8'h04;
   localparam logic [7:0] OFF_CONFIG    = 8'h08;
   localparam logic [7:0] OFF_CMD       = 8'h0c;
   localparam logic [7:0] OFF_ADDR      = 8'h10;
   localparam logic [7:0] OFF_STATUS    = 8'h14;
   localparam logic [7:0] OFF_ERASE_KEY = 8'h18;

   // ----------------------------------------------------------------------
   // Field layout and reset values
   // ----------------------------------------------------------------------
   localparam int         PROT_APP_LSB   = 0;
   localparam int         PROT_BOOT_LSB  = 2;
   localparam logic [1:0] PROT_UNPROG    = 2'h3;
   localparam logic [15:0] PTR_RESET     = 16'h0000;
   localparam logic [1:0] BOOT_SIZE_RST  = 2'h0;
   localparam int         PAGE_WORD_BITS = 6;
   localparam logic [31:0] ERASE_KEY    = 32'hc5e1a5e0;
   localparam int         CMD_STORE      = 0;
   localparam int         CMD_LOAD       = 1;
   localparam int         CMD_SETLOCK    = 2;
   localparam int         CMD_FROM_BOOT  = 3;

   // Bus transfer type and size codes
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD    = 3'h2;

   // Latched programming target, captured at operation start
   typedef struct packed {
      logic [15:0] ptr;
      logic        store;
      logic        load;
      logic        allowed;
   } fspg_op_t;
endpackage : fspg_pkg
`default_nettype wire

// ---- test/fspg_flash_model.sv ----
// Flash array stand-in: counts access pulses and keeps the last address.
`default_nettype none
module fspg_flash_model (
   input  wire logic        sys_clk,
   input  wire logic        arst_n,
   input  wire logic        store_en,
   input  wire logic        load_en,
   input  wire logic [15:0] addr,
   input  wire logic        byte_hi,
   output var int           n_store,
   output var int           n_load,
   output var logic [16:0]  last_addr
);
   timeunit 1ns;
   timeprecision 1ps;
   // Blocked accesses never arrive, so the counts show only what passed
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         n_store   <= 0;
         n_load    <= 0;
         last_addr <= 17'h0;
      end else begin
         if (store_en === 1'b1) n_store <= n_store + 1;
         if (load_en === 1'b1) n_load <= n_load + 1;
         if ((store_en | load_en) === 1'b1) last_addr <= {byte_hi, addr};
      end
   end
endmodule : fspg_flash_model
`default_nettype wire

// ---- test/fspg_guard_bench.sv ----
// Self-checking bench for the flash self-program guard, random commands over AHB-Lite.
`default_nettype none
module fspg_guard_bench;
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------------------------------------
   // Signals, design and flash stand-in
   // ----------------------------------------------------------------------
   logic        sys_clk = 1'b0;
   logic        arst_n = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic        ivec_in_boot = 1'b0;
   logic        hreadyout, irq_mask, flash_store_en, flash_load_en, flash_byte_hi, rdy_s;
   logic        hresp, rsp_s;
   logic [31:0] hrdata, rd_s;
   logic [15:0] flash_addr;
   logic [16:0] last_addr;
   int          n_store, n_load, n_fail = 0, comparisons = 0;

   always #5 sys_clk = ~sys_clk;
   // Bus as it stood at each rising edge, so reads never race the design
   always @(posedge sys_clk) begin
      rd_s  <= hrdata;
      rdy_s <= hreadyout;
      rsp_s <= hresp;
   end

   fspg_guard fspg_guard_inst (
      .sys_clk(sys_clk), .arst_n(arst_n), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(fspg_pkg::HSIZE_WORD), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ivec_in_boot(ivec_in_boot),
      .irq_mask(irq_mask), .flash_store_en(flash_store_en), .flash_load_en(flash_load_en),
      .flash_addr(flash_addr), .flash_byte_hi(flash_byte_hi)
   );
   fspg_flash_model fspg_flash_model_inst (
      .sys_clk(sys_clk), .arst_n(arst_n), .store_en(flash_store_en), .load_en(flash_load_en),
      .addr(flash_addr), .byte_hi(flash_byte_hi), .n_store(n_store), .n_load(n_load),
      .last_addr(last_addr)
   );

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   // Expected {blocked, load passed, store passed}; boot section lies above the boundary
   function automatic logic [2:0] exp_op(input logic [31:0] c, input logic [3:0] p,
                                         input logic [1:0] bsz);
      logic       tb, st, ld;
      logic [1:0] f;
      tb = c[31:16] >= (16'hffff << (12 - bsz));
      f  = tb ? p[3:2] : p[1:0];
      st = c[0] & c[3] & f[0];
      ld = c[1] & (f[1] | (c[3] == tb));
      return {(c[0] & ~st) | (c[1] & ~ld), ld, st};
   endfunction : exp_op

   task automatic stop_test;
      if (n_fail == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : stop_test

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // One single word transfer; the wait for hready is bounded
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      int n;
      n = 0;
      htrans <= fspg_pkg::HTRANS_NONSEQ;
      haddr  <= {24'h0, a};
      hwrite <= wr;
      do begin
         @(posedge sys_clk);
         #1;
         n++;
      end while (rdy_s !== 1'b1 && n < 16);
      htrans <= 2'h0;
      hwdata <= wd;
      do begin
         @(posedge sys_clk);
         #1;
         n++;
      end while (rdy_s !== 1'b1 && n < 32);
      rd = rd_s;
      chk("hresp", 32'h0, {31'h0, rsp_s});
      if (rdy_s !== 1'b1) begin
         n_fail++;
         $display("[ERR] hready expected 1 seen %b", rdy_s);
         stop_test();
      end
   endtask : bus

   // ----------------------------------------------------------------------
   // Main sequence: every field pair first, then random settings
   // ----------------------------------------------------------------------
   initial begin
      logic [31:0] r, d, c;
      logic [3:0]  p;
      logic [2:0]  e;
      int          s0, l0;
      r = 32'h6b30;
      repeat (2) @(posedge sys_clk);
      arst_n <= 1'b1;
      @(posedge sys_clk);
      #1;
      bus(1'b0, fspg_pkg::OFF_PROTECT, 32'h0, d);
      chk("protect_rst", 32'hf00, d & 32'hf00);
      bus(1'b0, 8'h1c, 32'h0, d);
      chk("unmapped", 32'h0, d);
      for (int i = 0; i < 48; i++) begin
         repeat (32) r = lfsr(r);
         p = (i < 16) ? i[3:0] : r[3:0];
         bus(1'b1, fspg_pkg::OFF_ERASE_KEY, fspg_pkg::ERASE_KEY, d);
         if (r[4]) bus(1'b1, fspg_pkg::OFF_PROTECT, {20'h0, p, 8'h0}, d);
         else bus(1'b1, fspg_pkg::OFF_CMD, {r[31:16], 4'h0, p, 8'h0c}, d);
         // An attempt to loosen must leave the fields as they are
         bus(1'b1, fspg_pkg::OFF_PROTECT, 32'hf00, d);
         bus(1'b0, fspg_pkg::OFF_PROTECT, 32'h0, d);
         chk("protect", {20'h0, p, 8'h0}, d & 32'hf00);
         bus(1'b1, fspg_pkg::OFF_CONFIG, {29'h0, r[7:5]}, d);
         ivec_in_boot <= r[8];
         c = {r[9] ? {4'hf, r[27:16]} : r[31:16], 12'h0, r[11], 1'b0, r[10], ~r[10]};
         s0 = n_store;
         l0 = n_load;
         bus(1'b1, fspg_pkg::OFF_CMD, c, d);
         bus(1'b1, fspg_pkg::OFF_POINTER, {16'h0, ~c[31:16]}, d);
         e = exp_op(c, p, r[6:5]);
         chk("stores", {31'h0, e[0]}, n_store - s0);
         chk("loads", {31'h0, e[1]}, n_load - l0);
         bus(1'b0, fspg_pkg::OFF_STATUS, 32'h0, d);
         chk("status", {29'h0, e}, d & 32'h7);
         if (e[1:0] != 2'b00) begin
            chk("last_addr", {15'h0, c[16], 1'b0, c[31:17]}, {15'h0, last_addr});
            chk("addr_held", {17'h0, c[31:17]}, {16'h0, flash_addr});
         end
         bus(1'b0, fspg_pkg::OFF_POINTER, 32'h0, d);
         chk("pointer", {16'h0, ~c[31:16]}, d & 32'hffff);
         chk("irq_mask", {31'h0, (~p[1] & r[8] & ~r[7]) | (~p[3] & ~r[8] & r[7])},
             {31'h0, irq_mask});
      end
      stop_test();
   end

   // Cuts a hung run short
   initial begin
      repeat (100000) @(posedge sys_clk);
      n_fail++;
      stop_test();
   end
endmodule : fspg_guard_bench
`default_nettype wire
